// ---- inc/clock_gate_pkg.sv ----
package clock_gate_pkg;
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // generators
    localparam int GEN_COUNT = 9;
    localparam int SEL_W = 4;

    // register offsets, byte addresses
    localparam logic [ADDR_W-1:0] CHAN_CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] GEN_CTRL_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] GEN_DIV_BASE = 8'h80;

    // channel_control_reg fields
    localparam int SEL_LSB = 0;
    localparam int CLOCK_ON_BIT = 14;
    localparam int LOCK_BIT = 15;

    // status register fields
    localparam int BUSY_BIT = 0;

    // generators reloaded with their own number after a user reset
    localparam logic [SEL_W-1:0] RELOAD_FIRST = 4'h4;
    localparam logic [SEL_W-1:0] RELOAD_LAST = 4'h8;

    // reset values
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
    localparam logic [DATA_W-1:0] GEN_CTRL_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] GEN_DIV_RESET = 32'h00000000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

    // enable crossing depth, in clock cycles
    localparam int SYNC_STAGES = 2;
endpackage : clock_gate_pkg

// ---- inc/sync_if.sv ----
interface sync_if;
    logic request;
    logic effective;
    logic busy;

    modport owner (output request, input effective, input busy);
    modport syncer (input request, output effective, output busy);
endinterface : sync_if

// ---- rtl/enable_sync.sv ----
module enable_sync (
    // clock and power reset
    input wire logic clk,
    input wire logic powerResetn,
    // enable crossing
    sync_if.syncer link
);
    logic stage1;
    logic stage2;

    always_ff @(posedge clk) begin
        if (!powerResetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= link.request;
            stage2 <= stage1;
        end
    end

    assign link.effective = stage2;
    assign link.busy = link.request != stage2;
endmodule : enable_sync

// ---- rtl/generic_clock_channel_gate.sv ----
// Summary of operation
// - enable bit crosses through synchronizer
// - enable reads old value while syncing
// - disable write clears busy after sync
// - disabled channel output has no edges
// - locked channel ignores control writes
// - only power reset clears lock
// - lock also freezes source generator registers
// - user reset reloads generators four..eight, except those in RTC use or feeding the locked channel
module generic_clock_channel_gate (
    // clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic powerResetn,
    // register port
    input wire logic [clock_gate_pkg::ADDR_W-1:0] addr,
    input wire logic [clock_gate_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [clock_gate_pkg::DATA_W-1:0] rdData,
    // generator outputs and real-time counter usage
    input wire logic [clock_gate_pkg::GEN_COUNT-1:0] genClkIn,
    input wire logic rtcGenValid,
    input wire logic [clock_gate_pkg::SEL_W-1:0] rtcGenSel,
    // gated channel clock toward the consumers
    output logic chanClk,
    output logic chanClkOn
);
    logic [clock_gate_pkg::SEL_W-1:0] generatorSelect;
    logic configWriteLock;
    logic [clock_gate_pkg::DATA_W-1:0] generator_control_reg [clock_gate_pkg::GEN_COUNT];
    logic [clock_gate_pkg::DATA_W-1:0] generator_divider_reg [clock_gate_pkg::GEN_COUNT];
    logic chanCtrlWrite;
    logic [clock_gate_pkg::DATA_W-1:0] next_rdData;

    sync_if enableLink ();

    enable_sync u_enable_sync (
        .clk(clk),
        .powerResetn(powerResetn),
        .link(enableLink.syncer)
    );

    // decodes a generator register window: {hit, index}
    function automatic logic [clock_gate_pkg::SEL_W:0] genHit(
        input logic [clock_gate_pkg::ADDR_W-1:0] a,
        input logic [clock_gate_pkg::ADDR_W-1:0] base
    );
        logic [clock_gate_pkg::ADDR_W-1:0] offs;
        offs = a - base;
        if (a >= base && a[1:0] == 2'b00
                && offs[clock_gate_pkg::ADDR_W-1:2] < clock_gate_pkg::GEN_COUNT) begin
            genHit = {1'b1, offs[clock_gate_pkg::SEL_W+1:2]};
        end else begin
            genHit = '0;
        end
    endfunction : genHit

    // true when generator i feeds the locked channel
    function automatic logic genLocked(input int i);
        genLocked = configWriteLock
            && generatorSelect == i[clock_gate_pkg::SEL_W-1:0];
    endfunction : genLocked

    assign chanCtrlWrite = wrStrobe && addr == clock_gate_pkg::CHAN_CTRL_ADDR
        && !configWriteLock;

    // lock falls only on power reset
    always_ff @(posedge clk) begin
        if (!powerResetn) begin
            configWriteLock <= 1'b0;
        end else if (chanCtrlWrite && wrData[clock_gate_pkg::LOCK_BIT]) begin
            configWriteLock <= 1'b1;
        end
    end

    // per-channel source choice; locked config survives user reset
    always_ff @(posedge clk) begin
        if (!powerResetn || (!resetn && !configWriteLock)) begin
            generatorSelect <= clock_gate_pkg::SEL_RESET;
            enableLink.request <= 1'b0;
        end else if (chanCtrlWrite) begin
            generatorSelect <= wrData[clock_gate_pkg::SEL_LSB +: clock_gate_pkg::SEL_W];
            enableLink.request <= wrData[clock_gate_pkg::CLOCK_ON_BIT];
        end
    end

    // generator control and divider registers
    always_ff @(posedge clk) begin
        logic [clock_gate_pkg::SEL_W:0] ctrlHit;
        logic [clock_gate_pkg::SEL_W:0] divHit;
        logic keep;
        ctrlHit = genHit(addr, clock_gate_pkg::GEN_CTRL_BASE);
        divHit = genHit(addr, clock_gate_pkg::GEN_DIV_BASE);
        for (int i = 0; i < clock_gate_pkg::GEN_COUNT; i++) begin
            keep = genLocked(i)
                || (rtcGenValid && rtcGenSel == i[clock_gate_pkg::SEL_W-1:0]);
            if (!powerResetn) begin
                generator_control_reg[i] <= clock_gate_pkg::GEN_CTRL_RESET;
                generator_divider_reg[i] <= clock_gate_pkg::GEN_DIV_RESET;
            end else if (!resetn) begin
                if (!keep) begin
                    if (i >= clock_gate_pkg::RELOAD_FIRST && i <= clock_gate_pkg::RELOAD_LAST) begin
                        generator_control_reg[i] <= clock_gate_pkg::DATA_W'(i);
                    end else begin
                        generator_control_reg[i] <= clock_gate_pkg::GEN_CTRL_RESET;
                    end
                    generator_divider_reg[i] <= clock_gate_pkg::GEN_DIV_RESET;
                end
            end else if (wrStrobe && !genLocked(i)) begin
                // source generator of locked channel frozen
                if (ctrlHit[clock_gate_pkg::SEL_W]
                        && ctrlHit[clock_gate_pkg::SEL_W-1:0] == i[clock_gate_pkg::SEL_W-1:0]) begin
                    generator_control_reg[i] <= wrData;
                end
                if (divHit[clock_gate_pkg::SEL_W]
                        && divHit[clock_gate_pkg::SEL_W-1:0] == i[clock_gate_pkg::SEL_W-1:0]) begin
                    generator_divider_reg[i] <= wrData;
                end
            end
        end
    end

    // read mux; data stands one cycle after the strobe
    always_comb begin
        logic [clock_gate_pkg::SEL_W:0] ctrlHit;
        logic [clock_gate_pkg::SEL_W:0] divHit;
        ctrlHit = genHit(addr, clock_gate_pkg::GEN_CTRL_BASE);
        divHit = genHit(addr, clock_gate_pkg::GEN_DIV_BASE);
        next_rdData = clock_gate_pkg::READ_ZERO;
        if (addr == clock_gate_pkg::CHAN_CTRL_ADDR) begin
            next_rdData[clock_gate_pkg::SEL_LSB +: clock_gate_pkg::SEL_W] = generatorSelect;
            next_rdData[clock_gate_pkg::CLOCK_ON_BIT] = enableLink.effective;
            next_rdData[clock_gate_pkg::LOCK_BIT] = configWriteLock;
        end else if (addr == clock_gate_pkg::STATUS_ADDR) begin
            next_rdData[clock_gate_pkg::BUSY_BIT] = enableLink.busy;
        end else if (ctrlHit[clock_gate_pkg::SEL_W]) begin
            next_rdData = generator_control_reg[ctrlHit[clock_gate_pkg::SEL_W-1:0]];
        end else if (divHit[clock_gate_pkg::SEL_W]) begin
            next_rdData = generator_divider_reg[divHit[clock_gate_pkg::SEL_W-1:0]];
        end
    end

    // zero outside the read cycle so stale data is never mistaken
    always_ff @(posedge clk) begin
        if (!powerResetn || !resetn || !rdStrobe) begin
            rdData <= clock_gate_pkg::READ_ZERO;
        end else begin
            rdData <= next_rdData;
        end
    end

    always_ff @(posedge clk) begin
        if (!powerResetn) begin
            chanClk <= 1'b0;
            chanClkOn <= 1'b0;
        end else begin
            // selects past the last generator give no clock rather than an unknown
            chanClk <= enableLink.effective && generatorSelect < clock_gate_pkg::GEN_COUNT
                && genClkIn[generatorSelect];
            chanClkOn <= enableLink.effective;
        end
    end
endmodule : generic_clock_channel_gate

// ---- dv/clock_consumer.sv ----
module clock_consumer (
    // clocks
    input wire logic clk,
    input wire logic chanClk,
    // rising edges seen
    output logic [15:0] edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    initial edges = 16'h0;
    // sampled on clk, as a clocked consumer would
    always @(posedge clk) begin
        last <= chanClk;
        if (chanClk && !last) begin
            edges <= edges + 16'h1;
        end
    end
endmodule : clock_consumer

// ---- dv/generic_clock_channel_gate_checker.sv ----
module gate_checker (
    // watched ports
    input wire logic clk,
    input wire logic resetn,
    input wire logic powerResetn,
    input wire logic [clock_gate_pkg::ADDR_W-1:0] addr,
    input wire logic [clock_gate_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [clock_gate_pkg::DATA_W-1:0] rdData,
    input wire logic chanClk,
    input wire logic chanClkOn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lk;
    logic en;
    logic cw;
    assign cw = wrStrobe && addr == 8'h00 && !lk;
    default clocking @(posedge clk); endclocking
    default disable iff (!powerResetn || !resetn);
    // shadow of the lock, cleared by power reset only
    always_ff @(posedge clk) begin
        if (!powerResetn) begin
            lk <= 1'b0;
        end else if (wrStrobe && addr == 8'h00 && wrData[15]) begin
            lk <= 1'b1;
        end
    end
    // shadow of the enable request; a locked channel keeps it through user reset
    always_ff @(posedge clk) begin
        if (!powerResetn || (!resetn && !lk)) begin
            en <= 1'b0;
        end else if (cw) begin
            en <= wrData[14];
        end
    end
    property p_rdIdle; !rdStrobe |=> rdData == 32'h0; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data not zero");
    property p_rdOn; rdStrobe && addr == 8'h00 |=> rdData[14] == chanClkOn; endproperty
    a_rdOn: assert property (p_rdOn) else $error("enable readback wrong");
    property p_on; cw && wrData[14] |-> ##4 chanClkOn; endproperty
    a_on: assert property (p_on) else $error("enable not effective");
    // request low long enough that nothing is still crossing
    property p_hold;
        cw && wrData[14] && !chanClkOn && !en && !$past(en) && !$past(en, 2)
            |=> !chanClkOn [*3];
    endproperty
    a_hold: assert property (p_hold) else $error("enable skipped crossing");
    property p_off; cw && !wrData[14] |-> ##4 !chanClkOn; endproperty
    a_off: assert property (p_off) else $error("disable not effective");
    property p_gate; !chanClkOn |-> !chanClk; endproperty
    a_gate: assert property (p_gate) else $error("clock edge while off");
    property p_lock; wrStrobe && addr == 8'h00 && lk |=> $stable(chanClkOn) [*4]; endproperty
    a_lock: assert property (p_lock) else $error("locked write took effect");
    property p_keep;
        disable iff (!powerResetn) !resetn && lk && chanClkOn |=> chanClkOn;
    endproperty
    a_keep: assert property (p_keep) else $error("user reset broke lock");
    cover property ($rose(chanClkOn));
    cover property ($fell(chanClkOn));
    cover property (!resetn && lk);
endmodule : gate_checker
bind generic_clock_channel_gate gate_checker u_chk (.clk, .resetn, .powerResetn, .addr,
    .wrData, .wrStrobe, .rdStrobe, .rdData, .chanClk, .chanClkOn);

// ---- dv/generic_clock_channel_gate_bench.sv ----
module generic_clock_channel_gate_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic powerResetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wrData = 32'h0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [31:0] rdData;
    logic [8:0] genClkIn = 9'h0;
    logic rtcGenValid = 1'b0;
    logic [3:0] rtcGenSel = 4'h0;
    logic chanClk;
    logic chanClkOn;
    logic [15:0] edges;
    logic [15:0] e0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    generic_clock_channel_gate uut (.clk, .resetn, .powerResetn, .addr, .wrData, .wrStrobe,
        .rdStrobe, .rdData, .genClkIn, .rtcGenValid, .rtcGenSel, .chanClk, .chanClkOn);
    clock_consumer peer (.clk, .chanClk, .edges);
    always #25 clk = ~clk;
    // generator i toggles every 2**i cycles
    always @(posedge clk) begin
        genClkIn <= genClkIn + 9'h1;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, exp, what);
    endtask : rd
    task rst(input logic pwr);
        @(posedge clk);
        resetn <= 1'b0;
        powerResetn <= !pwr;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        powerResetn <= 1'b1;
    endtask : rst
    // generator i has period 2**(i+1), so 32 cycles hold 32 >> (i+1) edges
    task win(input logic [31:0] exp, input string what);
        e0 = edges;
        repeat (32) @(posedge clk);
        #1;
        chk(32'(edges - e0), exp, what);
    endtask : win
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        powerResetn <= 1'b1;
        rd(8'hfc, 32'h0, "unmapped");
        for (int i = 0; i < 9; i++) begin
            wr(8'h40 + 8'(4 * i), 32'hff);
        end
        rtcGenValid <= 1'b1;
        rtcGenSel <= 4'h6;
        rst(1'b0);
        for (int i = 0; i < 9; i++) begin
            rd(8'h40 + 8'(4 * i), (i == 6) ? 32'hff : (i >= 4) ? 32'(i) : 32'h0, "gen");
        end
        wr(8'h00, 32'h3);
        wr(8'h00, 32'h4003);
        rd(8'h04, 32'h1, "busy");
        rd(8'h00, 32'h4003, "enabled");
        chk(32'(chanClkOn), 32'h1, "clock on");
        win(32'h2, "edges on");
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h4003, "old enable");
        rd(8'h04, 32'h0, "busy clear");
        rd(8'h00, 32'h3, "disabled");
        chk(32'(chanClkOn), 32'h0, "clock off");
        win(32'h0, "edges off");
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h4002);
        rd(8'h04, 32'h1, "busy again");
        rd(8'h00, 32'h4002, "new source");
        win(32'h4, "edges generator 2");
        wr(8'h54, 32'h55);
        wr(8'h94, 32'h77);
        wr(8'h00, 32'hc005);
        repeat (8) @(posedge clk);
        wr(8'h54, 32'hab);
        wr(8'h94, 32'hab);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'hc005, "locked ctrl");
        rd(8'h54, 32'h55, "locked gen ctrl");
        rd(8'h94, 32'h77, "locked gen div");
        rtcGenValid <= 1'b0;
        rst(1'b0);
        rd(8'h00, 32'hc005, "lock kept");
        rd(8'h54, 32'h55, "source kept");
        rd(8'h94, 32'h77, "divider kept");
        rd(8'h58, 32'h6, "gen6 reload");
        rst(1'b1);
        rd(8'h00, 32'h0, "power reset");
        print_verdict();
    end
endmodule : generic_clock_channel_gate_bench
